// file: rtl/ssp_pkg.sv
/*
  shared constants and carrier types of the synchronous slave serial port.
  assumes an apb master on pclk and an external master driving the shift clock.
*/
// Contract
// R1 - slave reception needs synchronous mode, port enable, master select cleared; clock from pin.
// R2 - continuous receive enable in slave mode lets the receiver shift words.
// R3 - in nine-bit reception the top bit appears in received_ninth_bit.
// R4 - each received word sets receive_flag; irq only with receive_irq_enable.
// R5 - low eight bits go through a fifo; reading receive_buffer pops oldest.
// R6 - overrun stays until continuous receive or port enable cleared; port disable resets all.
// R7 - in sleep only synchronous slave mode keeps shifting.
// R8 - slave shifters run only from the external shift clock.
// R9 - reading receive_buffer until empty clears receive_flag.
// R10 - external master drives shift clock and data for reception.
// R11 - word shifted in during sleep sets receive_flag and wakes core if enabled.
// R12 - core resumes after wake and vectors to 0004h when global irq enabled.
// R13 - transmit_buffer write clears transmit_flag; first fills shifter, second the buffer.
// R14 - transmit wake needs transmit_irq_enable and peripheral_irq_enable.
// R15 - master clocks the pin, device drives outgoing bits on the data pin.
// R16 - after last bit out, pending byte moves to shifter and transmit_flag sets.
// R17 - after handover the buffer takes a new byte, whose write clears the flag.
// R18 - both receive enables clear selects transmit, otherwise receive.
// R19 - nine-bit transmit sends transmit_ninth_bit as top bit.
// R20 - single receive enable ignored in slave; continuous receive never idles.
// R21 - master gives eight or nine pulses per word, no stray edges.
package ssp_pkg;

  localparam logic [7:0]  ADDR_RATE_CONTROL     = 8'h00;
  localparam logic [7:0]  ADDR_RECEIVE_BUFFER   = 8'h04;
  localparam logic [7:0]  ADDR_RECEIVE_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_TRANSMIT_STATUS  = 8'h0C;
  localparam logic [7:0]  ADDR_TRANSMIT_BUFFER  = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_CONTROL      = 8'h14;

  // receive_status_control
  localparam int          RS_PORT_ENABLE        = 7;
  localparam int          RS_RX9                = 6;
  localparam int          RS_SINGLE_RX          = 5;
  localparam int          RS_CONT_RX            = 4;
  localparam int          RS_OVERRUN            = 1;
  localparam int          RS_RX9_BIT            = 0;
  // transmit_status_control
  localparam int          TS_CLOCK_MASTER       = 7;
  localparam int          TS_TX9                = 6;
  localparam int          TS_TX_ENABLE          = 5;
  localparam int          TS_SYNC               = 4;
  localparam int          TS_SHIFTER_EMPTY      = 1;
  localparam int          TS_TX9_BIT            = 0;
  // rate_control
  localparam int          RC_RX_IDLE            = 6;
  // irq control
  localparam int          IC_RX_FLAG            = 0;
  localparam int          IC_TX_FLAG            = 1;
  localparam int          IC_RX_IE              = 2;
  localparam int          IC_TX_IE              = 3;
  localparam int          IC_PERIPH_IE          = 4;
  localparam int          IC_GLOBAL_IE          = 5;

  localparam logic [7:0]  REG_RESET             = 8'h00;
  localparam logic [15:0] IRQ_VECTOR_ADDR       = 16'h0004;
  localparam logic [3:0]  BITS_SHORT            = 4'h8;
  localparam logic [3:0]  BITS_LONG             = 4'h9;
  localparam int          RX_FIFO_DEPTH         = 2;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ssp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ssp_apb_rsp_s;

endpackage : ssp_pkg

// file: rtl/ssp_sync.sv
/*
  two flip-flop synchroniser for pin levels.
  assumes inputs are asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssp_sync_state_s;

  ssp_sync_state_s st;
  ssp_sync_state_s next_st;

  // first stage feeds only the second
  always_comb
  begin
    next_st.meta   = async_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.stable;

endmodule : ssp_sync
`default_nettype wire

// file: rtl/ssp_fifo.sv
/*
  small receive fifo, flip-flop storage, head word from registers.
  assumes push is never asserted while full.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  // status
  output logic                  full,
  output logic                  empty,
  output logic      [WIDTH-1:0] head
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } ssp_fifo_state_s;

  ssp_fifo_state_s st;
  ssp_fifo_state_s next_st;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  always_comb
  begin
    next_st = st;
    if (flush)
    begin
      next_st.wr_ptr = '0;
      next_st.rd_ptr = '0;
      next_st.count  = '0;
    end
    else
    begin
      if (push && !full)
      begin
        next_st.mem[st.wr_ptr] = push_data;
        next_st.wr_ptr         = ptr_inc(st.wr_ptr);
      end
      if (pop && !empty)
        next_st.rd_ptr = ptr_inc(st.rd_ptr);
      next_st.count = (AW+1)'(st.count + (push && !full) - (pop && !empty));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign full  = (st.count == (AW+1)'(DEPTH));
  assign empty = (st.count == '0);
  assign head  = st.mem[st.rd_ptr];

endmodule : ssp_fifo
`default_nettype wire

// file: rtl/ssp_port.sv
/*
  synchronous slave serial port: apb registers, receive and transmit shifters
  stepped by the sampled external shift clock, receive fifo, wake request.
  assumes the shift clock is far slower than pclk (at least four pclk per half period).
*/
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ssp_port #(
  parameter int FIFO_DEPTH = ssp_pkg::RX_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // register bus
  input  wire ssp_pkg::ssp_apb_req_s apb_req,
  output ssp_pkg::ssp_apb_rsp_s      apb_rsp,
  // serial pins
  input  wire logic                  clock_pin,
  input  wire logic                  data_pin_in,
  output logic                       data_pin_out,
  output logic                       data_pin_oe_n,
  // core side
  input  wire logic                  sleep_mode,
  output logic                       wake_request,
  output logic                       core_irq,
  output logic      [15:0]           irq_vector
);

  typedef struct packed {
    logic [7:0] prdata;
    logic       pslverr;
    logic       ck_prev;
    logic       port_enable;
    logic       rx9;
    logic       single_receive_enable;
    logic       continuous_receive_enable;
    logic       clock_source_master_select;
    logic       tx9;
    logic       txen;
    logic       sync_mode;
    logic       transmit_ninth_bit;
    logic       rx_ie;
    logic       tx_ie;
    logic       pe_ie;
    logic       g_ie;
    logic       overrun_error;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [7:0] tx_buf;
    logic       tx_buf_full;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt;
    logic       tx_busy;
  } ssp_port_state_s;

  ssp_port_state_s st;
  ssp_port_state_s next_st;

  logic       ck_s;
  logic       dt_s;
  logic       ck_rise;
  logic       ck_fall;
  logic       slave;
  logic       shift_ok;
  logic       tx_dir;
  logic       rx_flag;
  logic       tx_flag;
  logic       fifo_full;
  logic       fifo_empty;
  logic [8:0] fifo_head;
  logic       fifo_push;
  logic [8:0] fifo_data;
  logic       fifo_pop;
  logic       fifo_flush;
  logic       setup;
  logic       access;
  logic       wr_en;

  function automatic logic [3:0] word_bits(input logic nine);
    word_bits = nine ? ssp_pkg::BITS_LONG : ssp_pkg::BITS_SHORT;
  endfunction : word_bits

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ssp_pkg::ADDR_RATE_CONTROL)    || (a == ssp_pkg::ADDR_RECEIVE_BUFFER)
           || (a == ssp_pkg::ADDR_RECEIVE_STATUS)  || (a == ssp_pkg::ADDR_TRANSMIT_STATUS)
           || (a == ssp_pkg::ADDR_TRANSMIT_BUFFER) || (a == ssp_pkg::ADDR_IRQ_CONTROL);
  endfunction : addr_ok

  // both pins are asynchronous to pclk
  ssp_sync #(
    .W (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({clock_pin, data_pin_in}),
    .sync_out ({ck_s, dt_s})
  );

  ssp_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (fifo_flush),
    .push      (fifo_push),
    .push_data (fifo_data),
    .pop       (fifo_pop),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .head      (fifo_head)
  );

  assign ck_rise  = ck_s & ~st.ck_prev;
  assign ck_fall  = ~ck_s & st.ck_prev;
  assign slave    = st.port_enable & st.sync_mode & ~st.clock_source_master_select; // R1 R8
  // only the slave mode is built; its shifters need no pclk-derived rate,
  // so sleep does not gate them, while any other setting never shifts
  assign shift_ok = slave; // R7
  assign tx_dir   = ~st.continuous_receive_enable & ~st.single_receive_enable; // R18
  assign rx_flag  = ~fifo_empty; // R4 R9
  assign tx_flag  = ~st.tx_buf_full; // R13 R16
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign access   = apb_req.psel & apb_req.penable;
  assign wr_en    = access & apb_req.pwrite & ~st.pslverr;

  // receive completion and fifo traffic
  always_comb
  begin
    fifo_push  = 1'b0;
    fifo_data  = '0;
    fifo_flush = ~st.port_enable; // R6
    fifo_pop   = access & ~apb_req.pwrite & (apb_req.paddr == ssp_pkg::ADDR_RECEIVE_BUFFER); // R5
    // single receive enable is ignored; continuous receive alone arms it
    if (shift_ok && st.continuous_receive_enable && !st.overrun_error && ck_rise && // R2 R20
        (st.rx_cnt + 4'h1 == word_bits(st.rx9)))
    begin
      fifo_push = ~fifo_full;
      if (st.rx9)
        fifo_data = {dt_s, st.rx_shift[8:1]}; // R3
      else
        fifo_data = {1'b0, dt_s, st.rx_shift[8:2]};
    end
  end

  always_comb
  begin
    next_st         = st;
    next_st.ck_prev = ck_s;

    // register read data captured in setup so the answer comes from flops
    if (setup)
    begin
      next_st.pslverr = ~addr_ok(apb_req.paddr);
      next_st.prdata  = ssp_pkg::REG_RESET;
      unique case (apb_req.paddr)
        ssp_pkg::ADDR_RATE_CONTROL:
          next_st.prdata[ssp_pkg::RC_RX_IDLE] = ~(slave & st.continuous_receive_enable); // R20
        ssp_pkg::ADDR_RECEIVE_BUFFER:
          next_st.prdata = fifo_head[7:0]; // R5
        ssp_pkg::ADDR_RECEIVE_STATUS:
        begin
          next_st.prdata[ssp_pkg::RS_PORT_ENABLE] = st.port_enable;
          next_st.prdata[ssp_pkg::RS_RX9]         = st.rx9;
          next_st.prdata[ssp_pkg::RS_SINGLE_RX]   = st.single_receive_enable;
          next_st.prdata[ssp_pkg::RS_CONT_RX]     = st.continuous_receive_enable;
          next_st.prdata[ssp_pkg::RS_OVERRUN]     = st.overrun_error;
          next_st.prdata[ssp_pkg::RS_RX9_BIT]     = fifo_head[8]; // R3
        end
        ssp_pkg::ADDR_TRANSMIT_STATUS:
        begin
          next_st.prdata[ssp_pkg::TS_CLOCK_MASTER]  = st.clock_source_master_select;
          next_st.prdata[ssp_pkg::TS_TX9]           = st.tx9;
          next_st.prdata[ssp_pkg::TS_TX_ENABLE]     = st.txen;
          next_st.prdata[ssp_pkg::TS_SYNC]          = st.sync_mode;
          next_st.prdata[ssp_pkg::TS_SHIFTER_EMPTY] = ~st.tx_busy;
          next_st.prdata[ssp_pkg::TS_TX9_BIT]       = st.transmit_ninth_bit;
        end
        ssp_pkg::ADDR_IRQ_CONTROL:
        begin
          next_st.prdata[ssp_pkg::IC_RX_FLAG]   = rx_flag;
          next_st.prdata[ssp_pkg::IC_TX_FLAG]   = tx_flag;
          next_st.prdata[ssp_pkg::IC_RX_IE]     = st.rx_ie;
          next_st.prdata[ssp_pkg::IC_TX_IE]     = st.tx_ie;
          next_st.prdata[ssp_pkg::IC_PERIPH_IE] = st.pe_ie;
          next_st.prdata[ssp_pkg::IC_GLOBAL_IE] = st.g_ie;
        end
        default:
          next_st.prdata = ssp_pkg::REG_RESET;
      endcase
    end

    // register writes, status bits are read only
    if (wr_en)
    begin
      unique case (apb_req.paddr)
        ssp_pkg::ADDR_RECEIVE_STATUS:
        begin
          next_st.port_enable = apb_req.pwdata[ssp_pkg::RS_PORT_ENABLE];
          next_st.rx9         = apb_req.pwdata[ssp_pkg::RS_RX9];
          next_st.single_receive_enable        = apb_req.pwdata[ssp_pkg::RS_SINGLE_RX];
          next_st.continuous_receive_enable        = apb_req.pwdata[ssp_pkg::RS_CONT_RX];
        end
        ssp_pkg::ADDR_TRANSMIT_STATUS:
        begin
          next_st.clock_source_master_select      = apb_req.pwdata[ssp_pkg::TS_CLOCK_MASTER];
          next_st.tx9       = apb_req.pwdata[ssp_pkg::TS_TX9];
          next_st.txen      = apb_req.pwdata[ssp_pkg::TS_TX_ENABLE];
          next_st.sync_mode = apb_req.pwdata[ssp_pkg::TS_SYNC];
          next_st.transmit_ninth_bit      = apb_req.pwdata[ssp_pkg::TS_TX9_BIT];
        end
        ssp_pkg::ADDR_TRANSMIT_BUFFER:
        begin
          // a write to a full buffer replaces the pending byte
          next_st.tx_buf      = apb_req.pwdata[7:0];
          next_st.tx_buf_full = 1'b1; // R13 R17
        end
        ssp_pkg::ADDR_IRQ_CONTROL:
        begin
          next_st.rx_ie = apb_req.pwdata[ssp_pkg::IC_RX_IE];
          next_st.tx_ie = apb_req.pwdata[ssp_pkg::IC_TX_IE];
          next_st.pe_ie = apb_req.pwdata[ssp_pkg::IC_PERIPH_IE];
          next_st.g_ie  = apb_req.pwdata[ssp_pkg::IC_GLOBAL_IE];
        end
        default:
          next_st.pe_ie = st.pe_ie;
      endcase
    end

    // receive shifter, lsb first, sampled on the rising shift clock edge
    if (shift_ok && st.continuous_receive_enable && !st.overrun_error && ck_rise) // R2 R8 R11
    begin
      next_st.rx_shift = {dt_s, st.rx_shift[8:1]};
      if (st.rx_cnt + 4'h1 == word_bits(st.rx9))
      begin
        next_st.rx_cnt = '0;
        if (fifo_full)
          next_st.overrun_error = 1'b1; // R6
      end
      else
        next_st.rx_cnt = st.rx_cnt + 4'h1;
    end
    // clearing continuous receive drops a partial word and the overrun
    if (!st.continuous_receive_enable)
    begin
      next_st.rx_cnt = '0;
      next_st.overrun_error   = 1'b0; // R6
    end

    // transmit shifter, next bit presented on the falling shift clock edge
    if (st.tx_busy && shift_ok && ck_fall) // R8 R15
    begin
      next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
      if (st.tx_cnt + 4'h1 == word_bits(st.tx9))
        next_st.tx_busy = 1'b0;
      else
        next_st.tx_cnt = st.tx_cnt + 4'h1;
    end
    // handover of the pending byte; a write in the same cycle stays pending
    if (!st.tx_busy && st.tx_buf_full && shift_ok && tx_dir && st.txen)
    begin
      next_st.tx_shift    = {st.tx9 & st.transmit_ninth_bit, st.tx_buf}; // R19
      next_st.tx_cnt      = '0;
      next_st.tx_busy     = 1'b1;
      next_st.tx_buf_full = wr_en && (apb_req.paddr == ssp_pkg::ADDR_TRANSMIT_BUFFER); // R16 R17
    end

    // port disable resets the shifters, counters, overrun, busy and transmit buffer full flag
    if (!st.port_enable)
    begin
      next_st.rx_shift    = '0;
      next_st.rx_cnt      = '0;
      next_st.overrun_error        = 1'b0; // R6
      next_st.tx_shift    = '0;
      next_st.tx_cnt      = '0;
      next_st.tx_busy     = 1'b0;
      next_st.tx_buf_full = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign apb_rsp.prdata  = {24'h00_0000, st.prdata};
  assign apb_rsp.pready  = access;
  assign apb_rsp.pslverr = access & st.pslverr;

  assign data_pin_out  = st.tx_shift[0]; // R15
  assign data_pin_oe_n = ~(slave & tx_dir & st.txen & st.tx_busy);

  // wake works in sleep because the flags are set from the pin clock alone
  assign wake_request = st.pe_ie & ((rx_flag & st.rx_ie) | (tx_flag & st.tx_ie)); // R4 R11 R14
  assign core_irq     = wake_request & st.g_ie & ~sleep_mode; // R12
  assign irq_vector   = ssp_pkg::IRQ_VECTOR_ADDR; // R12

endmodule : ssp_port
`default_nettype wire

// file: tb/ssp_port_monitor.sv
/*
  checker for ssp_port: pin, wake and apb relations over time.
  assumes one pclk domain and the register offsets of ssp_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_port_monitor (
  // clock, reset, bus
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire ssp_pkg::ssp_apb_req_s apb_req,
  input wire ssp_pkg::ssp_apb_rsp_s apb_rsp,
  // pins and core side
  input wire logic                  clock_pin,
  input wire logic                  data_pin_in,
  input wire logic                  data_pin_out,
  input wire logic                  data_pin_oe_n,
  input wire logic                  sleep_mode,
  input wire logic                  wake_request,
  input wire logic                  core_irq,
  input wire logic [15:0]           irq_vector
);
  logic [3:0] quiet;
  logic       ck_q;
  logic [7:0] rs_q;
  logic       rx_dir;
  logic       pe_off;
  logic       acc;
  assign acc    = apb_req.psel && apb_req.penable;
  assign rx_dir = rs_q[ssp_pkg::RS_CONT_RX] || rs_q[ssp_pkg::RS_SINGLE_RX];
  assign pe_off = !rs_q[ssp_pkg::RS_PORT_ENABLE];
  // quiet: pclk since the last clock pin edge or bus cycle, saturating so it never wraps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet <= 4'h0;
      ck_q  <= 1'b0;
      rs_q  <= 8'h00;
    end
    else
    begin
      ck_q <= clock_pin;
      if (clock_pin != ck_q || apb_req.psel)
        quiet <= 4'h0;
      else if (quiet != 4'hF)
        quiet <= quiet + 4'h1;
      if (acc && apb_req.pwrite && apb_req.paddr == ssp_pkg::ADDR_RECEIVE_STATUS)
        rs_q <= apb_req.pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_vector_fixed: assert property (irq_vector == 16'h0004)
    else $error("irq vector not at fixed address");
  a_irq_asleep: assert property (sleep_mode |-> !core_irq)
    else $error("core interrupt while asleep");
  a_irq_cause: assert property (core_irq |-> wake_request)
    else $error("core interrupt without wake request");
  a_shift_ext: assert property (quiet >= 4'h8 |-> $stable(data_pin_out))
    else $error("data pin moved without shift clock");
  a_wake_cause: assert property ($rose(wake_request) |-> quiet <= 4'hA)
    else $error("wake request without word or bus cause");
  a_rx_no_drive: assert property (rx_dir && $past(rx_dir) && $past(rx_dir, 2) |-> data_pin_oe_n)
    else $error("data pin driven in receive direction");
  a_off_no_drive: assert property (pe_off && $past(pe_off) && $past(pe_off, 2) |-> data_pin_oe_n)
    else $error("data pin driven with port disabled");
  a_ready_access: assert property (acc |-> apb_rsp.pready && apb_rsp.prdata[31:8] == 24'h00_0000)
    else $error("register access not answered");
  c_wake: cover property ($rose(wake_request));
  c_drive: cover property ($fell(data_pin_oe_n));
  c_refuse: cover property (acc && apb_rsp.pslverr);
endmodule : ssp_port_monitor
bind ssp_port ssp_port_monitor mon_u (.pclk, .presetn, .apb_req, .apb_rsp, .clock_pin,
  .data_pin_in, .data_pin_out, .data_pin_oe_n, .sleep_mode, .wake_request, .core_irq,
  .irq_vector);
`default_nettype wire

// file: tb/ssp_link_master.sv
/*
  external synchronous master: drives the shift clock and resolves the data wire.
  assumes the port samples on rising and shifts on falling clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_link_master #(
  parameter int HALF_NS = 400
) (
  // pins
  output logic      clock_pin,
  output logic      data_pin_in,
  input  wire logic data_pin_out,
  input  wire logic data_pin_oe_n
);
  logic m_bit;
  // no pull on the wire: an undriven line shows the inverse of the last bit
  assign data_pin_in = !data_pin_oe_n ? data_pin_out : m_bit;
  initial
  begin
    clock_pin = 1'b0;
    m_bit     = 1'b0;
  end
  // clock stands low between words
  task automatic send(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      m_bit = w[i];
      #HALF_NS clock_pin = 1'b1;
      #HALF_NS clock_pin = 1'b0;
    end
    m_bit = ~m_bit;
  endtask : send
  task automatic recv(input int n, output logic [8:0] w);
    w = 9'h000;
    for (int i = 0; i < n; i++)
    begin
      #HALF_NS clock_pin = 1'b1;
      w[i] = data_pin_in;
      #HALF_NS clock_pin = 1'b0;
    end
    // a released wire must not keep showing the last driven bit
    m_bit = ~w[n-1];
  endtask : recv
endmodule : ssp_link_master
`default_nettype wire

// file: tb/ssp_port_test.sv
/*
  self-checking bench for ssp_port: apb tasks and a link master model.
  assumes pclk at 100 ns and the checker bound onto the port.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_port_test;
  logic                  pclk;
  logic                  presetn;
  ssp_pkg::ssp_apb_req_s apb_req;
  ssp_pkg::ssp_apb_rsp_s apb_rsp;
  logic                  clock_pin;
  logic                  data_pin_in;
  logic                  data_pin_out;
  logic                  data_pin_oe_n;
  logic                  sleep_mode;
  logic                  wake_request;
  logic                  core_irq;
  logic [15:0]           irq_vector;
  logic [8:0]            word;
  int                    err_count;
  int                    tests_run;
  ssp_port dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .clock_pin(clock_pin), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
    .data_pin_oe_n(data_pin_oe_n), .sleep_mode(sleep_mode), .wake_request(wake_request),
    .core_irq(core_irq), .irq_vector(irq_vector));
  ssp_link_master lnk_u (.clock_pin(clock_pin), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (apb_rsp.pready !== 1'b1 && ++n < 20);
    q = apb_rsp.prdata;
    check({31'h0, apb_rsp.pslverr}, {31'h0, a > 8'h14});
    check({31'h0, n == 20}, 32'h0000_0000);
    apb_req <= '0;
  endtask : xfer
  // the wait to the falling edge lets the write land before callers look at pins
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h00_0000, d}, q);
    @(negedge pclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    check(q, {24'h00_0000, exp});
  endtask : rd
  task automatic report_and_stop;
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #2_000_000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    apb_req    = '0;
    presetn    = 1'b0;
    sleep_mode = 1'b0;
    err_count  = 0;
    tests_run  = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ssp_pkg::ADDR_IRQ_CONTROL, 8'h02);
    rd(ssp_pkg::ADDR_RATE_CONTROL, 8'h40);
    rd(8'h18, 8'h00);
    check({16'h0000, irq_vector}, 32'h0000_0004);
    // receive a word while asleep
    wr(ssp_pkg::ADDR_TRANSMIT_STATUS, 8'h10);
    wr(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h90);
    rd(ssp_pkg::ADDR_RATE_CONTROL, 8'h00);
    wr(ssp_pkg::ADDR_IRQ_CONTROL, 8'h34);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    lnk_u.send(9'h03C, 8);
    repeat (8) @(posedge pclk);
    check({31'h0, wake_request}, 32'h0000_0001);
    check({31'h0, core_irq}, 32'h0000_0000);
    sleep_mode <= 1'b0;
    @(posedge pclk);
    check({31'h0, core_irq}, 32'h0000_0001);
    rd(ssp_pkg::ADDR_IRQ_CONTROL, 8'h37);
    rd(ssp_pkg::ADDR_RECEIVE_BUFFER, 8'h3C);
    rd(ssp_pkg::ADDR_IRQ_CONTROL, 8'h36);
    check({31'h0, wake_request}, 32'h0000_0000);
    // third word overruns the two-deep fifo
    for (int i = 1; i < 4; i++)
      lnk_u.send(9'h011 * 9'(i), 8);
    repeat (8) @(posedge pclk);
    rd(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h92);
    rd(ssp_pkg::ADDR_RECEIVE_BUFFER, 8'h11);
    rd(ssp_pkg::ADDR_RECEIVE_BUFFER, 8'h22);
    rd(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h92);
    wr(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h80);
    rd(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h80);
    // nine-bit receive
    wr(ssp_pkg::ADDR_RECEIVE_STATUS, 8'hD0);
    lnk_u.send(9'h1A5, 9);
    repeat (8) @(posedge pclk);
    rd(ssp_pkg::ADDR_RECEIVE_STATUS, 8'hD1);
    rd(ssp_pkg::ADDR_RECEIVE_BUFFER, 8'hA5);
    // transmit three queued bytes while asleep
    wr(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h80);
    wr(ssp_pkg::ADDR_TRANSMIT_STATUS, 8'h30);
    wr(ssp_pkg::ADDR_IRQ_CONTROL, 8'h08);
    check({31'h0, wake_request}, 32'h0000_0000);
    wr(ssp_pkg::ADDR_IRQ_CONTROL, 8'h18);
    check({31'h0, wake_request}, 32'h0000_0001);
    wr(ssp_pkg::ADDR_TRANSMIT_BUFFER, 8'hA5);
    wr(ssp_pkg::ADDR_TRANSMIT_BUFFER, 8'h5A);
    rd(ssp_pkg::ADDR_IRQ_CONTROL, 8'h18);
    check({31'h0, data_pin_oe_n}, 32'h0000_0000);
    sleep_mode <= 1'b1;
    lnk_u.recv(8, word);
    check({23'h0, word}, 32'h0000_00A5);
    repeat (8) @(posedge pclk);
    check({31'h0, wake_request}, 32'h0000_0001);
    rd(ssp_pkg::ADDR_IRQ_CONTROL, 8'h1A);
    wr(ssp_pkg::ADDR_TRANSMIT_BUFFER, 8'hC3);
    rd(ssp_pkg::ADDR_IRQ_CONTROL, 8'h18);
    for (int i = 0; i < 2; i++)
    begin
      lnk_u.recv(8, word);
      check({23'h0, word}, i ? 32'h0000_00C3 : 32'h0000_005A);
    end
    repeat (8) @(posedge pclk);
    check({31'h0, data_pin_oe_n}, 32'h0000_0001);
    // nine-bit transmit
    wr(ssp_pkg::ADDR_TRANSMIT_STATUS, 8'h71);
    wr(ssp_pkg::ADDR_TRANSMIT_BUFFER, 8'h3C);
    lnk_u.recv(9, word);
    check({23'h0, word}, 32'h0000_013C);
    // port disable with a word loaded but no shift clock edge yet stops the drive
    wr(ssp_pkg::ADDR_TRANSMIT_BUFFER, 8'h77);
    repeat (3) @(posedge pclk);
    check({31'h0, data_pin_oe_n}, 32'h0000_0000);
    wr(ssp_pkg::ADDR_RECEIVE_STATUS, 8'h00);
    repeat (2) @(posedge pclk);
    check({31'h0, data_pin_oe_n}, 32'h0000_0001);
    report_and_stop();
  end
endmodule : ssp_port_test
`default_nettype wire
